// [mdb_map.svh]
// Offsets, field positions, reset values and address constants of the memory decoder.
`ifndef MDB_MAP_SVH
`define MDB_MAP_SVH

`define MDB_OFS_FW_EN1        8'h00
`define MDB_OFS_FW_EN2        8'h04
`define MDB_OFS_CTRL          8'h08
`define MDB_OFS_LAN_BASE      8'h0c
`define MDB_OFS_BR_BASE       8'h10
`define MDB_OFS_BR_LIMIT      8'h14
`define MDB_OFS_SWAP          8'h18
`define MDB_OFS_STATUS        8'h1c
`define MDB_OFS_LAST_ADDR     8'h20

`define MDB_RST_FW_EN1        8'hff
`define MDB_RST_FW_EN2        4'hf
`define MDB_RST_SUB_EN        1'b0
`define MDB_RST_LAN_EN        1'b0
`define MDB_RST_LAN_BASE      20'h00000
`define MDB_RST_BR_BASE       12'hfff
`define MDB_RST_BR_LIMIT      12'h000

`define MDB_BIT_LEGACY        7
`define MDB_IDX_ALWAYS        7
`define MDB_BIT_SUB_EN        0
`define MDB_BIT_LAN_EN        0
`define MDB_BIT_SWAP          0
`define MDB_BIT_FORCED        1
`define MDB_BIT_A16           16

`define MDB_LOW_MAIN_END      32'h000d_ffff
`define MDB_HIGH_MAIN_BASE    32'h0010_0000
`define MDB_LEGACY_TAG        15'h0007
`define MDB_APIC_BASE         32'hfec0_0000
`define MDB_APIC_END          32'hfec0_0100
`define MDB_FW_TOP_TAG        9'h1ff
`define MDB_FW_LOW_TAG        9'h1fe
`define MDB_SWAP_TAG          15'h7fff

`endif

// [mdb_pkg.sv]
// Types shared by the memory decoder modules.
package mdb_pkg;

  typedef enum logic [2:0] {
    MDB_TGT_MAIN     = 3'b000,
    MDB_TGT_FIRMWARE = 3'b001,
    MDB_TGT_APIC     = 3'b010,
    MDB_TGT_LAN      = 3'b011,
    MDB_TGT_PCI      = 3'b100,
    MDB_TGT_HUB      = 3'b101,
    MDB_TGT_PEER     = 3'b110
  } mdb_target_t;

  typedef struct packed {
    logic [7:0]  fw_en1;
    logic [3:0]  fw_en2;
    logic        sub_en;
    logic        lan_en;
    logic [19:0] lan_base;
    logic [11:0] br_base;
    logic [11:0] br_limit;
    logic        ph_valid;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic [31:0] hrdata;
    logic        strap_s1;
    logic        strap_s2;
    logic        strap_s3;
    logic        forced;
    logic        captured;
    logic [1:0]  fill;
  } mdb_top_t;

  typedef struct packed {
    logic swap;
  } mdb_swap_t;

  typedef struct packed {
    logic        valid;
    mdb_target_t target;
    logic [31:0] addr;
    logic        pci_first;
    logic        swapped;
  } mdb_dec_t;

endpackage

// [mdb_if.sv]
// Carriers between the decoder top and its swap keeper and route decoder.
`timescale 1ns/100ps

interface mdb_swap_if;
  logic ce;
  logic wr;
  logic wdata;
  logic forced;
  logic swap;
  modport ctrl (output ce, output wr, output wdata, output forced, input swap);
  modport keep (input ce, input wr, input wdata, input forced, output swap);
endinterface

interface mdb_dec_if;
  import mdb_pkg::*;
  logic        ce;
  logic        req_valid;
  logic [31:0] req_addr;
  logic        req_from_master;
  logic        req_unclaimed;
  logic [7:0]  fw_en1;
  logic [3:0]  fw_en2;
  logic        sub_en;
  logic        lan_en;
  logic [19:0] lan_base;
  logic [11:0] br_base;
  logic [11:0] br_limit;
  logic [31:0] mem_limit;
  logic        swap;
  mdb_dec_t    rsp;
  modport ctrl (output ce, output req_valid, output req_addr, output req_from_master,
                output req_unclaimed, output fw_en1, output fw_en2, output sub_en,
                output lan_en, output lan_base, output br_base, output br_limit,
                output mem_limit, output swap, input rsp);
  modport dec (input ce, input req_valid, input req_addr, input req_from_master,
               input req_unclaimed, input fw_en1, input fw_en2, input sub_en,
               input lan_en, input lan_base, input br_base, input br_limit,
               input mem_limit, input swap, output rsp);
endinterface

// [mdb_swap_keep.sv]
// Battery-well keeper of the boot-block swap bit.
`timescale 1ns/100ps

module mdb_swap_keep
  import mdb_pkg::*;
(
  input  wire logic clk,          // System clock.
  input  wire logic rtc_rst_n,    // Battery-well reset, active low.
  mdb_swap_if.keep  sw            // Write and strap side.
);

  mdb_swap_t st;
  mdb_swap_t next_st;

  always_comb begin
    next_st = st;
    if (sw.wr) begin
      next_st.swap = sw.wdata;
    end
    if (sw.forced) begin
      next_st.swap = 1'b1;
    end
  end

  // Only the battery-well reset clears the bit; the bus reset never reaches it.
  always_ff @(posedge clk or negedge rtc_rst_n) begin
    if (!rtc_rst_n) begin
      st <= '0;
    end else if (sw.ce) begin
      st <= next_st;
    end
  end

  assign sw.swap = st.swap;

endmodule

// [mdb_route_dec.sv]
// Address decoder that picks the target of each memory cycle.
`timescale 1ns/100ps
`include "mdb_map.svh"

module mdb_route_dec
  import mdb_pkg::*;
(
  input  wire logic clk,          // System clock.
  input  wire logic rst,          // Bus reset, active high.
  mdb_dec_if.dec    d             // Request, settings and answer.
);

  mdb_dec_t    st;
  mdb_dec_t    next_st;
  logic [31:0] a;
  logic [7:0]  hit1;
  logic [3:0]  hit2;
  logic        legacy;
  logic        fw;
  logic        bios;
  logic        swap_apply;
  logic        apic;
  logic        mainm;
  logic        lan;
  logic        bridge;

  assign a = d.req_addr;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_fw
      if (gi == `MDB_IDX_ALWAYS) begin : g_top
        assign hit1[gi] = (a[31:23] == `MDB_FW_TOP_TAG) && (a[21:19] == 3'(gi));
      end else begin : g_en1
        assign hit1[gi] = (a[31:23] == `MDB_FW_TOP_TAG) && (a[21:19] == 3'(gi))
                          && d.fw_en1[gi];
      end
      if (gi < 4) begin : g_en2
        assign hit2[gi] = (a[31:23] == `MDB_FW_LOW_TAG) && (a[21:20] == 2'(gi))
                          && d.fw_en2[gi];
      end
    end
  endgenerate

  assign legacy     = (a[31:17] == `MDB_LEGACY_TAG) && d.fw_en1[`MDB_BIT_LEGACY];
  assign fw         = legacy || (|hit1) || (|hit2);
  // Upper alias of each pair is boot space, lower alias is feature space.
  assign bios       = ((a[31:23] == `MDB_FW_TOP_TAG) || (a[31:23] == `MDB_FW_LOW_TAG))
                      && a[22];
  assign swap_apply = d.swap && fw && bios && (a[31:17] == `MDB_SWAP_TAG);
  assign apic       = (a >= `MDB_APIC_BASE) && (a <= `MDB_APIC_END);
  assign mainm      = (a <= `MDB_LOW_MAIN_END)
                      || ((a >= `MDB_HIGH_MAIN_BASE) && (a < d.mem_limit));
  assign lan        = d.lan_en && (a[31:12] == d.lan_base);
  assign bridge     = (a[31:20] >= d.br_base) && (a[31:20] <= d.br_limit);

  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    if (d.req_valid) begin
      next_st.valid     = 1'b1;
      next_st.addr      = a ^ (32'(swap_apply) << `MDB_BIT_A16);
      next_st.swapped   = swap_apply;
      next_st.pci_first = !d.req_from_master;
      if (d.req_from_master) begin
        if (bridge) begin
          next_st.target = MDB_TGT_PEER;
        end else if (apic) begin
          next_st.target = MDB_TGT_APIC;
        end else if (fw) begin
          next_st.target = MDB_TGT_FIRMWARE;
        end else begin
          next_st.target = MDB_TGT_HUB;
        end
      end else begin
        if (apic) begin
          next_st.target = MDB_TGT_APIC;
        end else if (fw) begin
          next_st.target = MDB_TGT_FIRMWARE;
        end else if (lan) begin
          next_st.target = MDB_TGT_LAN;
        end else if (mainm) begin
          next_st.target = MDB_TGT_MAIN;
        end else if (d.req_unclaimed && d.sub_en) begin
          next_st.target = MDB_TGT_FIRMWARE;
        end else begin
          next_st.target = MDB_TGT_PCI;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{valid: 1'b0, target: MDB_TGT_PCI, addr: 32'h0000_0000,
              pci_first: 1'b0, swapped: 1'b0};
    end else if (d.ce) begin
      st <= next_st;
    end
  end

  assign d.rsp = st;

endmodule

// [mdb_top.sv]
// Memory-cycle decoder with firmware enables, boot-block swap and AHB-Lite registers.
//
// Behaviour
// - Hub cycles go onto PCI first; the device then claims firmware, APIC or LAN ones.
// - With subtractive decode on, an unclaimed hub cycle goes to the firmware bus.
// - Master cycles are positively decoded; the bridge window is left to peers.
// - Master cycles missing the bridge window, APIC and firmware ranges are sent up the hub.
// - Zero to 000D_FFFF and 1 MB up to the memory limit are main memory.
// - Segments E and F go to firmware only while enable bit 7 is set.
// - FEC0_0000 through FEC0_0100 belong to the internal I/O APIC.
// - First enable bits 0 to 6 each gate one 512 KB range pair.
// - The top 512 KB pair always goes to firmware.
// - Second enable bits 0 to 3 each gate one 1 MB range pair.
// - A LAN window anywhere in 4 GB, enabled by its base; all else goes to PCI.
// - With swap set, A16 is inverted for firmware boot space from FFFE_0000 up; else unchanged.
// - Swap bit clears on the battery-well reset only, not on bus reset.
// - Swap bit lives in the battery-backed well.
// - A strap forces swap on; software cannot clear it until reboot without strap.
// - Inversion touches boot space only, never feature space.
// - Addresses below FFFE_0000 are never swapped.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "mdb_map.svh"

module mdb_top
  import mdb_pkg::*;
(
  input  wire logic        CLK_SYS,              // System clock, 10 MHz.
  input  wire logic        RST,                  // Bus reset, active high, asynchronous.
  input  wire logic        CE,                   // Clock enable; low freezes all state.
  input  wire logic        RTC_WELL_RESET_N,     // Battery-well reset, active low.
  input  wire logic        STRAP_SWAP,           // Strap pin forcing swap mode.
  input  wire logic [31:0] TOP_OF_MEMORY_LIMIT,  // Main memory limit from host controller.
  input  wire logic        REQ_VALID,            // Memory cycle to decode.
  input  wire logic [31:0] REQ_ADDR,             // Cycle address.
  input  wire logic        REQ_FROM_MASTER,      // Cycle from an external PCI master.
  input  wire logic        REQ_UNCLAIMED,        // Hub cycle that went unclaimed on PCI.
  input  wire logic        HSEL,                 // AHB slave select.
  input  wire logic [31:0] HADDR,                // AHB address.
  input  wire logic [1:0]  HTRANS,               // AHB transfer type.
  input  wire logic        HWRITE,               // AHB write.
  input  wire logic [2:0]  HSIZE,                // AHB size, word only.
  input  wire logic [31:0] HWDATA,               // AHB write data.
  input  wire logic        HREADY,               // AHB bus ready.
  output      logic        HREADYOUT,            // AHB slave ready.
  output      logic        HRESP,                // AHB response, always OKAY.
  output      logic [31:0] HRDATA,               // AHB read data.
  output      logic        ROUTE_VALID,          // Decode result pulse.
  output      logic [2:0]  ROUTE_TARGET,         // Chosen target.
  output      logic [31:0] ROUTE_ADDR,           // Address after swap.
  output      logic        ROUTE_PCI_FIRST,      // Cycle is driven on PCI before claim.
  output      logic        SWAP_ACTIVE           // Swap bit state.
);

  mdb_top_t   st;
  mdb_top_t   next_st;
  mdb_swap_if sw ();
  mdb_dec_if  dq ();
  logic       wr_fire;
  logic       wr_swap;
  logic       swap_view;

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules.

  mdb_swap_keep u_swap (
    .clk       (CLK_SYS),
    .rtc_rst_n (RTC_WELL_RESET_N),
    .sw        (sw.keep)
  );

  mdb_route_dec u_dec (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (dq.dec)
  );

  assign wr_fire  = st.ph_valid && st.ph_write;
  assign wr_swap  = wr_fire && (st.ph_addr == `MDB_OFS_SWAP);

  assign sw.ce     = CE;
  assign sw.wr     = wr_swap;
  assign sw.wdata  = HWDATA[`MDB_BIT_SWAP];
  assign sw.forced = st.forced;

  // Read data of the swap register follows a write landing in the same cycle.
  assign swap_view = wr_swap ? (HWDATA[`MDB_BIT_SWAP] || st.forced) : sw.swap;

  assign dq.ce              = CE;
  assign dq.req_valid       = REQ_VALID;
  assign dq.req_addr        = REQ_ADDR;
  assign dq.req_from_master = REQ_FROM_MASTER;
  assign dq.req_unclaimed   = REQ_UNCLAIMED;
  assign dq.fw_en1          = st.fw_en1;
  assign dq.fw_en2          = st.fw_en2;
  assign dq.sub_en          = st.sub_en;
  assign dq.lan_en          = st.lan_en;
  assign dq.lan_base        = st.lan_base;
  assign dq.br_base         = st.br_base;
  assign dq.br_limit        = st.br_limit;
  assign dq.mem_limit       = TOP_OF_MEMORY_LIMIT;
  assign dq.swap            = sw.swap;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and strap capture.

  always_comb begin
    next_st = st;

    // Strap is caught once after bus reset, when the last two stages agree.
    // The fill count keeps the reset contents of the stages from being caught.
    next_st.strap_s1 = STRAP_SWAP;
    next_st.strap_s2 = st.strap_s1;
    next_st.strap_s3 = st.strap_s2;
    if (st.fill != 2'd3) begin
      next_st.fill = st.fill + 2'd1;
    end
    if (!st.captured && (st.fill == 2'd3) && (st.strap_s2 == st.strap_s3)) begin
      next_st.forced   = st.strap_s3;
      next_st.captured = 1'b1;
    end

    if (wr_fire) begin
      if (st.ph_addr == `MDB_OFS_FW_EN1) begin
        next_st.fw_en1 = HWDATA[7:0];
      end else if (st.ph_addr == `MDB_OFS_FW_EN2) begin
        next_st.fw_en2 = HWDATA[3:0];
      end else if (st.ph_addr == `MDB_OFS_CTRL) begin
        next_st.sub_en = HWDATA[`MDB_BIT_SUB_EN];
      end else if (st.ph_addr == `MDB_OFS_LAN_BASE) begin
        next_st.lan_base = HWDATA[31:12];
        next_st.lan_en   = HWDATA[`MDB_BIT_LAN_EN];
      end else if (st.ph_addr == `MDB_OFS_BR_BASE) begin
        next_st.br_base = HWDATA[31:20];
      end else if (st.ph_addr == `MDB_OFS_BR_LIMIT) begin
        next_st.br_limit = HWDATA[31:20];
      end
    end

    next_st.ph_valid = 1'b0;
    if (HREADY) begin
      next_st.ph_valid = HSEL && HTRANS[1];
      next_st.ph_write = HWRITE;
      next_st.ph_addr  = HADDR[7:0];
      if (HSEL && HTRANS[1] && !HWRITE) begin
        if (HADDR[7:0] == `MDB_OFS_FW_EN1) begin
          next_st.hrdata = {24'h000000, next_st.fw_en1};
        end else if (HADDR[7:0] == `MDB_OFS_FW_EN2) begin
          next_st.hrdata = {28'h0000000, next_st.fw_en2};
        end else if (HADDR[7:0] == `MDB_OFS_CTRL) begin
          next_st.hrdata = {31'h00000000, next_st.sub_en};
        end else if (HADDR[7:0] == `MDB_OFS_LAN_BASE) begin
          next_st.hrdata = {next_st.lan_base, 11'h000, next_st.lan_en};
        end else if (HADDR[7:0] == `MDB_OFS_BR_BASE) begin
          next_st.hrdata = {next_st.br_base, 20'h00000};
        end else if (HADDR[7:0] == `MDB_OFS_BR_LIMIT) begin
          next_st.hrdata = {next_st.br_limit, 20'h00000};
        end else if (HADDR[7:0] == `MDB_OFS_SWAP) begin
          next_st.hrdata = {30'h00000000, st.forced, swap_view};
        end else if (HADDR[7:0] == `MDB_OFS_STATUS) begin
          next_st.hrdata = {27'h0000000, dq.rsp.swapped, dq.rsp.pci_first, dq.rsp.target};
        end else if (HADDR[7:0] == `MDB_OFS_LAST_ADDR) begin
          next_st.hrdata = dq.rsp.addr;
        end else begin
          next_st.hrdata = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st <= '{fw_en1: `MDB_RST_FW_EN1, fw_en2: `MDB_RST_FW_EN2, sub_en: `MDB_RST_SUB_EN,
              lan_en: `MDB_RST_LAN_EN, lan_base: `MDB_RST_LAN_BASE,
              br_base: `MDB_RST_BR_BASE, br_limit: `MDB_RST_BR_LIMIT,
              ph_valid: 1'b0, ph_write: 1'b0, ph_addr: 8'h00, hrdata: 32'h0000_0000,
              strap_s1: 1'b0, strap_s2: 1'b0, strap_s3: 1'b0,
              forced: 1'b0, captured: 1'b0, fill: 2'b00};
    end else if (CE) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign HREADYOUT       = 1'b1;
  assign HRESP           = 1'b0;
  assign HRDATA          = st.hrdata;
  assign ROUTE_VALID     = dq.rsp.valid;
  assign ROUTE_TARGET    = dq.rsp.target;
  assign ROUTE_ADDR      = dq.rsp.addr;
  assign ROUTE_PCI_FIRST = dq.rsp.pci_first;
  assign SWAP_ACTIVE     = sw.swap;

endmodule

// [mdb_top_chk_sva.sv]
// Port assertions and covers for the memory decoder top.
`timescale 1ns/100ps

module mdb_top_chk
  import mdb_pkg::*;
(
  input wire logic        CLK_SYS,           // System clock.
  input wire logic        RST,               // Bus reset.
  input wire logic        CE,                // Clock enable.
  input wire logic        RTC_WELL_RESET_N,  // Battery-well reset.
  input wire logic        REQ_VALID,         // Cycle strobe.
  input wire logic [31:0] REQ_ADDR,          // Cycle address.
  input wire logic        REQ_FROM_MASTER,   // Cycle from a PCI master.
  input wire logic        HREADYOUT,         // Slave ready.
  input wire logic        HRESP,             // Slave response.
  input wire logic        ROUTE_VALID,       // Result pulse.
  input wire logic [2:0]  ROUTE_TARGET,      // Chosen target.
  input wire logic [31:0] ROUTE_ADDR,        // Address after swap.
  input wire logic        ROUTE_PCI_FIRST,   // Driven on PCI first.
  input wire logic        SWAP_ACTIVE        // Swap bit.
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic hub_req;
  assign hub_req = REQ_VALID && CE && !REQ_FROM_MASTER;

  property p_pci_first;
    REQ_VALID && CE |=> ROUTE_VALID && (ROUTE_PCI_FIRST == !$past(REQ_FROM_MASTER));
  endproperty
  a_pci_first:
    assert property (p_pci_first) else $error("pci first flag wrong");
  property p_main_low;
    hub_req && REQ_ADDR <= 32'h000d_ffff |=> ROUTE_TARGET == MDB_TGT_MAIN;
  endproperty
  a_main_low:
    assert property (p_main_low) else $error("low memory not main");
  property p_apic;
    hub_req && REQ_ADDR >= 32'hfec0_0000 && REQ_ADDR <= 32'hfec0_0100
      |=> ROUTE_TARGET == MDB_TGT_APIC;
  endproperty
  a_apic:
    assert property (p_apic) else $error("apic range not claimed");
  property p_top_pair;
    hub_req && (REQ_ADDR[31:19] == 13'h1fff || REQ_ADDR[31:19] == 13'h1ff7)
      |=> ROUTE_TARGET == MDB_TGT_FIRMWARE;
  endproperty
  a_top_pair:
    assert property (p_top_pair) else $error("top pair not firmware");
  property p_swap_low;
    REQ_VALID && CE && REQ_ADDR < 32'hfffe_0000 |=> ROUTE_ADDR == $past(REQ_ADDR);
  endproperty
  a_swap_low:
    assert property (p_swap_low) else $error("low address altered");
  property p_swap_inv;
    hub_req && SWAP_ACTIVE && REQ_ADDR >= 32'hfffe_0000
      |=> ROUTE_ADDR == ($past(REQ_ADDR) ^ 32'h0001_0000);
  endproperty
  a_swap_inv:
    assert property (p_swap_inv) else $error("boot block not swapped");
  property p_no_swap;
    REQ_VALID && CE && !SWAP_ACTIVE |=> ROUTE_ADDR == $past(REQ_ADDR);
  endproperty
  a_no_swap:
    assert property (p_no_swap) else $error("address altered without swap");
  property p_swap_hold;
    @(posedge CLK_SYS) disable iff (!RTC_WELL_RESET_N) RST |=> $stable(SWAP_ACTIVE);
  endproperty
  a_swap_hold:
    assert property (p_swap_hold) else $error("swap bit lost on bus reset");
  property p_okay;
    HREADYOUT && !HRESP;
  endproperty
  a_okay:
    assert property (p_okay) else $error("bus slave not ready or not okay");
  c_fw: cover property (ROUTE_VALID && ROUTE_TARGET == MDB_TGT_FIRMWARE);
  c_swap: cover property ($rose(SWAP_ACTIVE));
  c_peer: cover property (ROUTE_VALID && ROUTE_TARGET == MDB_TGT_PEER);
endmodule

bind mdb_top mdb_top_chk u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .RTC_WELL_RESET_N(RTC_WELL_RESET_N),
  .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_FROM_MASTER(REQ_FROM_MASTER),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ROUTE_VALID(ROUTE_VALID),
  .ROUTE_TARGET(ROUTE_TARGET), .ROUTE_ADDR(ROUTE_ADDR),
  .ROUTE_PCI_FIRST(ROUTE_PCI_FIRST), .SWAP_ACTIVE(SWAP_ACTIVE));

// [mdb_cyc_src.sv]
// Model of the hub and the PCI masters that issue memory cycles.
`timescale 1ns/100ps

module mdb_cyc_src #(
  parameter logic [31:0] MEM_LIMIT = 32'h1000_0000  // Main memory limit.
) (
  input  wire logic        clk,         // System clock.
  output      logic        req_valid,   // Cycle strobe.
  output      logic [31:0] req_addr,    // Cycle address.
  output      logic        req_master,  // Cycle from a PCI master.
  output      logic        req_uncl,    // Hub cycle left unclaimed on PCI.
  output      logic [31:0] mem_limit    // Memory limit of the host controller.
);
  initial begin
    req_valid  = 1'b0;
    req_addr   = 32'h0;
    req_master = 1'b0;
    req_uncl   = 1'b0;
    mem_limit  = MEM_LIMIT;
  end

  // Released address lines show a changed value so stale data never looks valid.
  task automatic issue(input logic [31:0] a, input logic m, input logic u);
    @(posedge clk);
    req_valid  <= 1'b1;
    req_addr   <= a;
    req_master <= m;
    req_uncl   <= u && !m;
    @(posedge clk);
    req_valid  <= 1'b0;
    req_addr   <= ~a;
  endtask
endmodule

// [mdb_top_bench.sv]
// Self-checking bench of the memory decoder top.
`timescale 1ns/100ps
`include "mdb_map.svh"

module mdb_top_bench;
  import mdb_pkg::*;
  logic        clk_sys, rst, rtc_rst_n, strap, hsel, hwrite, hreadyout, hresp;
  logic        req_valid, req_master, req_uncl, route_valid, route_pci_first, swap_active;
  logic [1:0]  htrans;
  logic [2:0]  route_target;
  logic [31:0] haddr, hwdata, hrdata, req_addr, mem_limit, route_addr, q;
  int          n_fail, n_checks;

  mdb_cyc_src src (.clk(clk_sys), .req_valid(req_valid), .req_addr(req_addr),
    .req_master(req_master), .req_uncl(req_uncl), .mem_limit(mem_limit));

  mdb_top DUT (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .RTC_WELL_RESET_N(rtc_rst_n),
    .STRAP_SWAP(strap), .TOP_OF_MEMORY_LIMIT(mem_limit), .REQ_VALID(req_valid),
    .REQ_ADDR(req_addr), .REQ_FROM_MASTER(req_master), .REQ_UNCLAIMED(req_uncl),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .ROUTE_VALID(route_valid), .ROUTE_TARGET(route_target),
    .ROUTE_ADDR(route_addr), .ROUTE_PCI_FIRST(route_pci_first),
    .SWAP_ACTIVE(swap_active));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_rdy;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) return;
    end
    n_fail++;
    close_out();
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic dec(input logic [31:0] a, input logic m, input logic u,
                     input logic [2:0] t, input logic [31:0] ea);
    int i;
    src.issue(a, m, u);
    #1;
    for (i = 0; i < 8 && route_valid !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 8) begin
      n_fail++;
      close_out();
    end
    chk({29'h0, route_target}, {29'h0, t});
    chk(route_addr, ea);
    chk({31'h0, route_pci_first}, {31'h0, !m});
  endtask

  // Holds one of the two resets for two edges, then lets the strap settle.
  task automatic pulse(input logic bus);
    @(posedge clk_sys);
    if (bus) rst <= 1'b1;
    else rtc_rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst       <= 1'b0;
    rtc_rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    {rst, rtc_rst_n, strap, hsel, hwrite} = 5'b10000;
    {htrans, haddr, hwdata} = '0;
    repeat (10) @(posedge clk_sys);
    rst       <= 1'b0;
    rtc_rst_n <= 1'b1;
    rd(`MDB_OFS_FW_EN1, 32'h0000_00ff);
    rd(`MDB_OFS_FW_EN2, 32'h0000_000f);
    rd(`MDB_OFS_CTRL, 32'h0);
    rd(`MDB_OFS_SWAP, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    dec(32'h0000_1000, 0, 0, MDB_TGT_MAIN, 32'h0000_1000);
    dec(32'h000d_ffff, 0, 0, MDB_TGT_MAIN, 32'h000d_ffff);
    dec(32'h000e_0000, 0, 0, MDB_TGT_FIRMWARE, 32'h000e_0000);
    dec(32'h0010_0000, 0, 0, MDB_TGT_MAIN, 32'h0010_0000);
    dec(32'h1000_0000, 0, 0, MDB_TGT_PCI, 32'h1000_0000);
    dec(32'hfec0_0100, 0, 0, MDB_TGT_APIC, 32'hfec0_0100);
    dec(32'hfec0_0104, 0, 0, MDB_TGT_PCI, 32'hfec0_0104);
    dec(32'h2000_0000, 0, 1, MDB_TGT_PCI, 32'h2000_0000);
    dec(32'h2000_0000, 1, 0, MDB_TGT_HUB, 32'h2000_0000);
    dec(32'hfec0_0000, 1, 0, MDB_TGT_APIC, 32'hfec0_0000);
    dec(32'hff80_0000, 1, 0, MDB_TGT_FIRMWARE, 32'hff80_0000);
    dec(32'hffff_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hffff_0000);
    wr(`MDB_OFS_FW_EN1, 32'h0);
    wr(`MDB_OFS_FW_EN2, 32'h0);
    wr(`MDB_OFS_CTRL, 32'h1);
    wr(`MDB_OFS_LAN_BASE, 32'h8000_1001);
    wr(`MDB_OFS_BR_BASE, 32'h9000_0000);
    wr(`MDB_OFS_BR_LIMIT, 32'h9000_0000);
    rd(`MDB_OFS_FW_EN1, 32'h0);
    dec(32'h000e_0000, 0, 0, MDB_TGT_PCI, 32'h000e_0000);
    dec(32'hffc0_0000, 0, 0, MDB_TGT_PCI, 32'hffc0_0000);
    dec(32'hff30_0000, 0, 0, MDB_TGT_PCI, 32'hff30_0000);
    dec(32'hfff8_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hfff8_0000);
    dec(32'hffbf_ffff, 0, 0, MDB_TGT_FIRMWARE, 32'hffbf_ffff);
    dec(32'h3000_0000, 0, 1, MDB_TGT_FIRMWARE, 32'h3000_0000);
    dec(32'h8000_1004, 0, 0, MDB_TGT_LAN, 32'h8000_1004);
    dec(32'h9000_0000, 1, 0, MDB_TGT_PEER, 32'h9000_0000);
    dec(32'h9010_0000, 1, 0, MDB_TGT_HUB, 32'h9010_0000);
    for (int k = 0; k < 7; k++) begin
      wr(`MDB_OFS_FW_EN1, 32'h1 << k);
      dec(32'hffc0_0000 + k * 32'h8_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hffc0_0000 + k * 32'h8_0000);
      dec(32'hff80_0000 + k * 32'h8_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hff80_0000 + k * 32'h8_0000);
    end
    for (int k = 0; k < 4; k++) begin
      wr(`MDB_OFS_FW_EN2, 32'h1 << k);
      dec(32'hff40_0000 + k * 32'h10_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hff40_0000 + k * 32'h10_0000);
      dec(32'hff00_0000 + k * 32'h10_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hff00_0000 + k * 32'h10_0000);
    end
    wr(`MDB_OFS_SWAP, 32'h1);
    rd(`MDB_OFS_SWAP, 32'h1);
    dec(32'hffff_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hfffe_0000);
    dec(32'hfffe_1234, 0, 0, MDB_TGT_FIRMWARE, 32'hffff_1234);
    dec(32'hffbf_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hffbf_0000);
    dec(32'hfffd_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hfffd_0000);
    pulse(1'b1);
    rd(`MDB_OFS_SWAP, 32'h1);
    rd(`MDB_OFS_FW_EN1, 32'h0000_00ff);
    pulse(1'b0);
    rd(`MDB_OFS_SWAP, 32'h0);
    strap <= 1'b1;
    pulse(1'b1);
    rd(`MDB_OFS_SWAP, 32'h3);
    wr(`MDB_OFS_SWAP, 32'h0);
    rd(`MDB_OFS_SWAP, 32'h3);
    dec(32'hffff_0000, 0, 0, MDB_TGT_FIRMWARE, 32'hfffe_0000);
    rd(`MDB_OFS_STATUS, 32'h0000_0019);
    rd(`MDB_OFS_LAST_ADDR, 32'hfffe_0000);
    strap <= 1'b0;
    pulse(1'b1);
    wr(`MDB_OFS_SWAP, 32'h0);
    rd(`MDB_OFS_SWAP, 32'h0);
    chk({31'h0, swap_active}, 32'h0);
    close_out();
  end
endmodule
